// ### core/rsb_status_bank.sv
`timescale 1ns/1ns
// How it works
// - one bank per port, selected by port select
// - forward channel status loads sensor registers automatically
// - voltage levels in bits 6:4 and 2:0
// - temperature level in bits 2:0, rest zero
// - camera error flags in bits 4:0
// - count parity errors; restart on lock, low read
// - low byte read clears high; high read doesn't
// - self-test error count reads as 8 bits
module rsb_status_bank
  import rsb_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_ack_out,
  input wire logic [NUM_PORTS-1:0] fc_status_valid_in,
  input wire rsb_status_s [NUM_PORTS-1:0] fc_status_in,
  input wire logic [NUM_PORTS-1:0] parity_err_in,
  input wire logic [NUM_PORTS-1:0] lock_valid_in,
  input wire logic [NUM_PORTS-1:0] [7:0] bist_err_count_in
);

  // ---------------------------------------------------------------
  // port select register
  // ---------------------------------------------------------------
  logic [7:0] port_select;                       // software written selector
  logic [7:0] next_port_select;
  logic [PORT_IDX_W-1:0] sel;                    // selected port index

  assign sel = port_select[PORT_SEL_LSB +: PORT_IDX_W];

  // load the selector on a write to its offset
  always_comb begin
    next_port_select = port_select;
    if (reg_wr_in && reg_addr_in == ADDR_PORT_SEL) begin
      next_port_select = reg_wdata_in;
    end
  end

  // register the selector
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      port_select <= BYTE_ZERO;
    end else begin
      port_select <= next_port_select;
    end
  end

  // ---------------------------------------------------------------
  // per port status and counters
  // ---------------------------------------------------------------
  rsb_status_s status [NUM_PORTS];               // latest forwarded status
  logic [PAR_CNT_W-1:0] par_cnt [NUM_PORTS];     // parity error counters
  logic [7:0] bist_cnt [NUM_PORTS];              // self-test error counts

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      rsb_status_s next_status;
      logic [PAR_CNT_W-1:0] next_par_cnt;
      logic [7:0] next_bist_cnt;
      logic lo_read;                             // low byte read of this port

      assign lo_read = reg_rd_in && reg_addr_in == ADDR_PAR_LO && sel == PORT_IDX_W'(p);

      // next status, counter and self-test count
      always_comb begin
        next_status = status[p];
        if (fc_status_valid_in[p]) begin
          next_status = fc_status_in[p];
        end
        next_bist_cnt = bist_err_count_in[p];
        next_par_cnt = par_cnt[p];
        if (lock_valid_in[p] || lo_read) begin
          // restart; an error in the same cycle is still counted
          next_par_cnt = parity_err_in[p] ? PAR_CNT_ONE : PAR_CNT_ZERO;
        end else if (parity_err_in[p] && par_cnt[p] != PAR_CNT_MAX) begin
          next_par_cnt = par_cnt[p] + PAR_CNT_ONE;
        end
      end

      // register the per port state
      always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
          status[p] <= STATUS_RESET;
          par_cnt[p] <= PAR_CNT_ZERO;
          bist_cnt[p] <= BYTE_ZERO;
        end else begin
          status[p] <= next_status;
          par_cnt[p] <= next_par_cnt;
          bist_cnt[p] <= next_bist_cnt;
        end
      end

      // assertions on status loading and counter behaviour
      sequence seq_lo_read;
        lo_read && !parity_err_in[p];
      endsequence

      AST_STATUS_LOAD: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        fc_status_valid_in[p] |=> status[p] == $past(fc_status_in[p]))
        else $error("forwarded status not loaded");
      AST_PAR_INC: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        parity_err_in[p] && !lock_valid_in[p] && !lo_read && par_cnt[p] != PAR_CNT_MAX
        |=> par_cnt[p] == $past(par_cnt[p]) + PAR_CNT_ONE)
        else $error("parity error not counted");
      AST_LOCK_RESTART: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        lock_valid_in[p] && !parity_err_in[p] |=> par_cnt[p] == PAR_CNT_ZERO)
        else $error("lock did not restart counter");
      AST_LO_CLEAR: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        seq_lo_read |=> par_cnt[p] == PAR_CNT_ZERO ##1 ($past(parity_err_in[p]) || par_cnt[p] == PAR_CNT_ZERO))
        else $error("low byte read did not clear count");
      AST_HI_KEEP: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        reg_rd_in && reg_addr_in == ADDR_PAR_HI && !lock_valid_in[p]
        |=> par_cnt[p] >= $past(par_cnt[p]))
        else $error("high byte read cleared count");
      AST_SATURATE: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        par_cnt[p] == PAR_CNT_MAX && !lock_valid_in[p] && !lo_read |=> par_cnt[p] == PAR_CNT_MAX)
        else $error("parity counter wrapped");
      // self-test count follows its input one cycle later
      AST_BIST_TRACK: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        resetn_in |=> bist_cnt[p] == $past(bist_err_count_in[p]))
        else $error("self-test count not tracked");
    end
  endgenerate

  // ---------------------------------------------------------------
  // read mux and answer
  // ---------------------------------------------------------------
  logic [7:0] next_rdata;
  logic next_ack;

  // decode the offset against the selected port's bank
  always_comb begin
    next_rdata = BYTE_ZERO;
    next_ack = reg_rd_in || reg_wr_in;
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_PORT_SEL: begin
          next_rdata = port_select;
        end
        ADDR_ALARM: begin
          next_rdata[ALARM_MSB:0] = status[sel].alarm;
        end
        ADDR_VOLT: begin
          next_rdata[VOLT1_MSB:VOLT1_LSB] = status[sel].second_voltage_level;
          next_rdata[VOLT0_MSB:VOLT0_LSB] = status[sel].first_voltage_level;
        end
        ADDR_TEMP: begin
          next_rdata[TEMP_MSB:TEMP_LSB] = status[sel].temp_level;
        end
        ADDR_CAM_ERR: begin
          next_rdata[CAM_MSB:0] = status[sel].cam_err;
        end
        ADDR_PAR_HI: begin
          next_rdata = par_cnt[sel][PAR_CNT_W-1:PAR_HI_LSB];
        end
        ADDR_PAR_LO: begin
          next_rdata = par_cnt[sel][PAR_LO_MSB:0];
        end
        ADDR_BIST: begin
          next_rdata = bist_cnt[sel];
        end
        default: begin
          next_rdata = BYTE_ZERO;                // unmapped reads zero
        end
      endcase
    end
  end

  // register the answer
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= BYTE_ZERO;
      reg_ack_out <= 1'b0;
    end else begin
      reg_rdata_out <= next_rdata;
      reg_ack_out <= next_ack;
    end
  end

  // ---------------------------------------------------------------
  // assertions on the read path
  // ---------------------------------------------------------------
  sequence seq_read(logic [7:0] a);
    reg_rd_in && reg_addr_in == a;
  endsequence

  AST_PORT_SEL: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    reg_wr_in && reg_addr_in == ADDR_PORT_SEL |=> port_select == $past(reg_wdata_in))
    else $error("port select not written");
  AST_VOLT_READ: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    seq_read(ADDR_VOLT) |=> reg_rdata_out[VOLT1_MSB:VOLT1_LSB] == $past(status[sel].second_voltage_level)
    && reg_rdata_out[VOLT0_MSB:VOLT0_LSB] == $past(status[sel].first_voltage_level)
    && reg_rdata_out[7] == 1'b0 && reg_rdata_out[3] == 1'b0)
    else $error("voltage level read wrong");
  AST_TEMP_READ: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    seq_read(ADDR_TEMP) |=> reg_rdata_out == {5'h00, $past(status[sel].temp_level)})
    else $error("temperature read wrong");
  AST_CAM_READ: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    seq_read(ADDR_CAM_ERR) |=> reg_rdata_out == {3'h0, $past(status[sel].cam_err)})
    else $error("camera error read wrong");
  AST_LO_DATA: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    seq_read(ADDR_PAR_LO) |=> reg_ack_out && reg_rdata_out == $past(par_cnt[sel][PAR_LO_MSB:0]))
    else $error("low byte read wrong");
  AST_BIST_READ: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    seq_read(ADDR_BIST) |=> reg_rdata_out == $past(bist_cnt[sel]))
    else $error("self-test count read wrong");
  // alarm flags come from the selected port, upper bits zero
  AST_ALARM_READ: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    seq_read(ADDR_ALARM) |=> reg_rdata_out == {2'h0, $past(status[sel].alarm)})
    else $error("alarm flags read wrong");
  // high byte returns the upper count bits of the selected port
  AST_HI_DATA: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    seq_read(ADDR_PAR_HI) |=> reg_rdata_out == $past(par_cnt[sel][PAR_CNT_W-1:PAR_HI_LSB]))
    else $error("high byte read wrong");
endmodule

// ### core/rsb_pkg.sv
package rsb_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_PORTS = 2;                 // receive ports with their own bank
  localparam int PORT_IDX_W = 1;                // width of a port index
  localparam int PAR_CNT_W = 16;                // parity error counter width

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_SEL = 8'h4C;   // receive port select
  localparam logic [7:0] ADDR_ALARM = 8'h51;      // sensor_alarm_flags
  localparam logic [7:0] ADDR_VOLT = 8'h52;       // voltage_levels
  localparam logic [7:0] ADDR_TEMP = 8'h53;       // temperature_level
  localparam logic [7:0] ADDR_CAM_ERR = 8'h54;    // camera_if_error_flags
  localparam logic [7:0] ADDR_PAR_HI = 8'h55;     // parity_count_high
  localparam logic [7:0] ADDR_PAR_LO = 8'h56;     // parity_count_low
  localparam logic [7:0] ADDR_BIST = 8'h57;       // self_test_error_count

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int VOLT1_MSB = 6;                  // second_voltage_level
  localparam int VOLT1_LSB = 4;
  localparam int VOLT0_MSB = 2;                  // first_voltage_level
  localparam int VOLT0_LSB = 0;
  localparam int TEMP_MSB = 2;                   // temperature level
  localparam int TEMP_LSB = 0;
  localparam int ALARM_MSB = 5;                  // alarm flags
  localparam int CAM_MSB = 4;                    // camera error flags
  localparam int PAR_LO_MSB = 7;                 // top bit of the low count byte
  localparam int PAR_HI_LSB = 8;                 // first bit of the high count byte
  localparam int PORT_SEL_LSB = 0;               // port index in port select
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [PAR_CNT_W-1:0] PAR_CNT_MAX = 16'hFFFF;
  localparam logic [PAR_CNT_W-1:0] PAR_CNT_ONE = 16'h0001;
  localparam logic [PAR_CNT_W-1:0] PAR_CNT_ZERO = 16'h0000;

  // ---------------------------------------------------------------
  // status word carried by the forward channel
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ALARM_MSB:0] alarm;                   // alarm flags
    logic [2:0] second_voltage_level;
    logic [2:0] first_voltage_level;
    logic [2:0] temp_level;
    logic [CAM_MSB:0] cam_err;                   // header_double_bit_flag .. control_error_flag
  } rsb_status_s;

  localparam rsb_status_s STATUS_RESET = '0;
endpackage

// ### tb/rsb_ser_model.sv
`timescale 1ns/1ns
// serializer far side: status words, parity errors, lock, self-test counts
module rsb_ser_model
  import rsb_pkg::*;
(
  input wire logic clk_in,
  output logic [NUM_PORTS-1:0] valid_out,
  output rsb_status_s [NUM_PORTS-1:0] status_out,
  output logic [NUM_PORTS-1:0] err_out,
  output logic [NUM_PORTS-1:0] lock_out,
  output logic [NUM_PORTS-1:0] [7:0] bist_out
);
  initial begin
    valid_out = '0;
    status_out = '0;
    err_out = '0;
    lock_out = '0;
    bist_out = '0;
  end
  // one status word per pulse; the bus shows the inverse once released
  task automatic send(input int p, input rsb_status_s w);
    @(posedge clk_in) valid_out[p] <= 1'b1;
    status_out[p] <= w;
    @(posedge clk_in) valid_out[p] <= 1'b0;
    status_out[p] <= ~w;
  endtask
  // parity error line held high for n cycles, one error per cycle
  task automatic errs(input int p, input int n);
    @(posedge clk_in) err_out[p] <= 1'b1;
    repeat (n) @(posedge clk_in);
    err_out[p] <= 1'b0;
  endtask
  // one-cycle lock detection pulse
  task automatic lock(input int p);
    @(posedge clk_in) lock_out[p] <= 1'b1;
    @(posedge clk_in) lock_out[p] <= 1'b0;
  endtask
  // self-test count level
  task automatic bist(input int p, input logic [7:0] v);
    @(posedge clk_in) bist_out[p] <= v;
  endtask
endmodule

// ### tb/rsb_status_bank_tb_top.sv
`timescale 1ns/1ns
module rsb_status_bank_tb_top
  import rsb_pkg::*;
;
  // ---------------------------------------------------------------
  // clock, reset, bus
  // ---------------------------------------------------------------
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [7:0] reg_addr_in = '0;
  logic reg_rd_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic [7:0] reg_wdata_in = '0;
  logic [7:0] reg_rdata_out;
  logic reg_ack_out;
  logic [NUM_PORTS-1:0] fv, fe, fl;
  rsb_status_s [NUM_PORTS-1:0] fs;
  logic [NUM_PORTS-1:0] [7:0] fb;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  always #20 core_clk_in = ~core_clk_in;
  rsb_status_bank rsb_status_bank_inst (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
    .fc_status_valid_in(fv), .fc_status_in(fs), .parity_err_in(fe), .lock_valid_in(fl),
    .bist_err_count_in(fb));
  rsb_ser_model rsb_ser_model_inst (.clk_in(core_clk_in), .valid_out(fv), .status_out(fs),
    .err_out(fe), .lock_out(fl), .bist_out(fb));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // read: strobe one cycle, ack and data land the cycle after
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_in) reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in) reg_rd_in <= 1'b0;
    #1 chk({7'h00, reg_ack_out}, 8'h01);
    chk(reg_rdata_out, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in) reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in) reg_wr_in <= 1'b0;
    #1 chk({7'h00, reg_ack_out}, 8'h01);
  endtask
  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // reset values, reserved bits and an unmapped offset
  task automatic t_reset();
    for (int a = 8'h51; a <= 8'h57; a++) rd(a[7:0], 8'h00);
    rd(8'h60, 8'h00);
  endtask
  // per-port copies loaded from the forward channel
  task automatic t_status();
    rsb_ser_model_inst.send(1, {6'h2A, 3'h5, 3'h3, 3'h6, 5'h15});
    rsb_ser_model_inst.send(0, {6'h15, 3'h2, 3'h7, 3'h1, 5'h0A});
    wr(ADDR_PORT_SEL, 8'h01);
    rd(ADDR_PORT_SEL, 8'h01);
    rd(ADDR_ALARM, 8'h2A);
    rd(ADDR_VOLT, 8'h53);
    rd(ADDR_TEMP, 8'h06);
    rd(ADDR_CAM_ERR, 8'h15);
    wr(ADDR_PORT_SEL, 8'h00);
    rd(ADDR_ALARM, 8'h15);
    rd(ADDR_VOLT, 8'h27);
    rd(ADDR_TEMP, 8'h01);
    rd(ADDR_CAM_ERR, 8'h0A);
  endtask
  // parity count: high read keeps it, low read clears both, lock restarts
  task automatic t_parity();
    rsb_ser_model_inst.errs(0, 259);
    rsb_ser_model_inst.errs(1, 4);
    // parity line is quiet before the count bytes are read
    repeat (2) rd(ADDR_PAR_HI, 8'h01);
    rd(ADDR_PAR_LO, 8'h03);
    rd(ADDR_PAR_HI, 8'h00);
    rd(ADDR_PAR_LO, 8'h00);
    wr(ADDR_PORT_SEL, 8'h01);
    rd(ADDR_PAR_LO, 8'h04);
    rsb_ser_model_inst.errs(1, 2);
    rsb_ser_model_inst.lock(1);
    rd(ADDR_PAR_LO, 8'h00);
    rsb_ser_model_inst.errs(1, 65540);
    rd(ADDR_PAR_HI, 8'hFF);
    rd(ADDR_PAR_LO, 8'hFF);
  endtask
  // self-test count per port
  task automatic t_bist();
    rsb_ser_model_inst.bist(1, 8'hA5);
    rd(ADDR_BIST, 8'hA5);
    wr(ADDR_PORT_SEL, 8'h00);
    rd(ADDR_BIST, 8'h00);
  endtask
  // ---------------------------------------------------------------
  // sequence and timeout
  // ---------------------------------------------------------------
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_status();
    t_parity();
    t_bist();
    wrap_up();
  end
endmodule
